// [src/rdf_filter.sv]
// Purpose: receive destination address filter with register file
// Assumes: frame bytes from the receive mac on core_clk, no fcs
// Notes: frame is held back until the source address is seen
`timescale 1ns/100ps
// What this block does
// - perfect: pass only exact station match
// - inverse perfect: pass non-matching destinations
// - hash only: all frames through hash
// - inverse hash only: pass hash rejects
// - default: unicast exact, multicast hash
// - inverse hash perfect: pass default rejects
// - promiscuous: accept every frame that the receive enables and own source drop let through
// - unicast hash, multicast always passed
// - unicast exact, multicast always passed
// - multicast hash, unicast always passed
// - multicast exact, unicast always passed
// - optionally drop own source address
// - first destination bit picks multicast
// - compare against station or hash registers
module rdf_filter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // receive byte stream in
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxLast,
  // filtered stream to receive queue
  output logic qValid,
  output logic [7:0] qData,
  output logic qLast
);
  import rdf_pkg::*;
  // all checks run on core_clk and rest during reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  typedef enum {ST_IDLE, ST_HEAD, ST_REPLAY, ST_PASS, ST_DROP} rdf_state_t;

  // registers
  logic [15:0] ctrlOne_ff, nxt_ctrlOne;
  logic [15:0] ctrlTwo_ff, nxt_ctrlTwo;
  logic [15:0] station_ff [3], nxt_station [3];
  logic [15:0] hash_ff [4], nxt_hash [4];
  logic [31:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  logic waitReq_ff, nxt_waitReq;
  logic wrNow;
  logic [15:0] dropCnt_ff, nxt_dropCnt;
  logic lastAccept_ff, nxt_lastAccept;
  // frame path
  rdf_state_t state_ff, nxt_state;
  logic [7:0] head_ff [HEADER_BYTES], nxt_head [HEADER_BYTES];
  logic [3:0] cnt_ff, nxt_cnt;
  logic qValid_ff, nxt_qValid;
  logic [7:0] qData_ff, nxt_qData;
  logic qLast_ff, nxt_qLast;
  logic [5:0] hashIdx;
  logic crcClear;
  logic crcFeed;
  logic [47:0] stationAddr;
  logic [47:0] destAddr;
  logic [47:0] srcAddr;
  logic [63:0] hashTable;
  logic isMulti, daExact, hashHit, accept, saDrop, decideNow;
  logic [3:0] scheme;

  // station address word k carries bytes 2k, 2k+1, first wire byte lowest
  function automatic logic [47:0] pack6(input logic [7:0] b [HEADER_BYTES], input int base);
    logic [47:0] r;
    r = '0;
    for (int i = 0; i < ADDR_BYTES; i++) begin
      r[8*i +: 8] = b[base + i];
    end
    return r;
  endfunction

  // merge a 16-bit register with byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign stationAddr = {station_ff[2], station_ff[1], station_ff[0]};
  assign hashTable = {hash_ff[3], hash_ff[2], hash_ff[1], hash_ff[0]};
  assign destAddr = pack6(head_ff, 0);
  assign srcAddr = pack6(head_ff, ADDR_BYTES);
  assign isMulti = head_ff[0][0]; // first bit on the wire
  assign daExact = (destAddr == stationAddr);
  assign hashHit = hashTable[hashIdx];
  assign saDrop = ctrlTwo_ff[RXC2_SA_DROP] && (srcAddr == stationAddr);

  // scheme decode on pass-all, inverse, physical select, multicast select
  always_comb begin
    logic all, inv, phy, mul, base;
    all = ctrlOne_ff[RXC_ALL];
    inv = ctrlOne_ff[RXC_INVERSE];
    phy = ctrlOne_ff[RXC_PHYS_SEL];
    mul = ctrlOne_ff[RXC_MULTI_SEL];
    base = 1'b0;
    case ({all, inv, phy, mul})
      4'b0011: base = daExact;
      4'b0111: base = !daExact;
      4'b0000: base = hashHit;
      4'b0100: base = !hashHit;
      4'b0010: base = isMulti ? hashHit : daExact;
      4'b0110: base = !(isMulti ? hashHit : daExact);
      4'b1100: base = 1'b1;
      4'b1000: base = isMulti ? 1'b1 : hashHit;
      4'b1011: base = isMulti ? 1'b1 : daExact;
      4'b1010: base = isMulti ? hashHit : 1'b1;
      4'b1001: base = isMulti ? daExact : 1'b1;
      default: base = 1'b0;
    endcase
    // enables are software's job; honoured here as gates
    accept = base && !saDrop && ctrlOne_ff[RXC_ENABLE]
             && (isMulti ? ctrlOne_ff[RXC_MULTI_EN] : ctrlOne_ff[RXC_UNI_EN]);
  end

  // crc runs over the six destination bytes only
  assign crcClear = (state_ff == ST_IDLE);
  assign crcFeed = rxValid && (state_ff == ST_HEAD || state_ff == ST_IDLE)
                   && (cnt_ff < 4'(ADDR_BYTES));

  rdf_hash_crc u_crc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(crcClear),
    .byteValid(crcFeed),
    .byteData(rxData),
    .hashIdx(hashIdx)
  );

  // frame path: buffer header, decide, then replay or discard
  always_comb begin
    nxt_state = state_ff;
    nxt_head = head_ff;
    nxt_cnt = cnt_ff;
    nxt_qValid = 1'b0;
    nxt_qData = qData_ff;
    nxt_qLast = 1'b0;
    nxt_dropCnt = dropCnt_ff;
    nxt_lastAccept = lastAccept_ff;
    case (state_ff)
      ST_IDLE, ST_HEAD: begin
        if (rxValid) begin
          nxt_head[cnt_ff] = rxData;
          nxt_cnt = cnt_ff + 4'd1;
          nxt_state = ST_HEAD;
          if (rxLast) begin
            // runt frame: ends within the twelve header bytes, discard
            nxt_state = ST_IDLE;
            nxt_cnt = '0;
            nxt_dropCnt = dropCnt_ff + 16'd1;
          end else if (cnt_ff == 4'(HEADER_BYTES - 1)) begin
            nxt_state = ST_REPLAY;
            nxt_cnt = '0;
          end
        end
      end
      ST_REPLAY: begin
        // decision taken once the header is complete
        if (cnt_ff == '0 && !accept) begin
          nxt_state = ST_DROP;
          nxt_lastAccept = 1'b0;
          nxt_dropCnt = dropCnt_ff + 16'd1;
        end else begin
          nxt_lastAccept = 1'b1;
          nxt_qValid = 1'b1;
          nxt_qData = head_ff[cnt_ff];
          nxt_cnt = cnt_ff + 4'd1;
          if (cnt_ff == 4'(HEADER_BYTES - 1)) begin
            nxt_state = ST_PASS;
            nxt_cnt = '0;
          end
        end
      end
      ST_PASS: begin
        if (rxValid) begin
          nxt_qValid = 1'b1;
          nxt_qData = rxData;
          nxt_qLast = rxLast;
          if (rxLast) begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_DROP: begin
        if (rxValid && rxLast) begin
          nxt_state = ST_IDLE; // rest of frame swallowed
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      qValid_ff <= 1'b0;
      qData_ff <= 8'h00;
      qLast_ff <= 1'b0;
      dropCnt_ff <= 16'h0000;
      lastAccept_ff <= 1'b0;
      for (int i = 0; i < HEADER_BYTES; i++) begin
        head_ff[i] <= 8'h00;
      end
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      qValid_ff <= nxt_qValid;
      qData_ff <= nxt_qData;
      qLast_ff <= nxt_qLast;
      dropCnt_ff <= nxt_dropCnt;
      lastAccept_ff <= nxt_lastAccept;
      head_ff <= nxt_head;
    end
  end

  // register slave: one wait cycle, then the answer; a write lands on the answer edge
  assign wrNow = avs_write && ack_ff;
  always_comb begin
    nxt_ctrlOne = ctrlOne_ff;
    nxt_ctrlTwo = ctrlTwo_ff;
    nxt_station = station_ff;
    nxt_hash = hash_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = 1'b0;
    if (avs_read || avs_write) begin
      nxt_ack = !ack_ff;
      nxt_rdata = 32'h00000000; // unmapped reads give zero
      case (avs_address)
        ADDR_RX_CTRL_ONE: begin
          nxt_rdata = {16'h0000, ctrlOne_ff};
          if (wrNow) nxt_ctrlOne = merge16(ctrlOne_ff, avs_writedata, avs_byteenable);
        end
        ADDR_RX_CTRL_TWO: begin
          nxt_rdata = {16'h0000, ctrlTwo_ff};
          if (wrNow) nxt_ctrlTwo = merge16(ctrlTwo_ff, avs_writedata, avs_byteenable);
        end
        ADDR_STATION_LOW, ADDR_STATION_MID, ADDR_STATION_HIGH: begin
          nxt_rdata = {16'h0000, station_ff[avs_address[3:2]]};
          if (wrNow) begin
            nxt_station[avs_address[3:2]] =
              merge16(station_ff[avs_address[3:2]], avs_writedata, avs_byteenable);
          end
        end
        ADDR_FRAME_STAT: nxt_rdata = {30'h0, lastAccept_ff, state_ff == ST_DROP};
        ADDR_DROP_COUNT: nxt_rdata = {16'h0000, dropCnt_ff};
        default: begin
          if (avs_address[7:4] == ADDR_HASH_BASE[7:4]) begin
            nxt_rdata = {16'h0000, hash_ff[avs_address[3:2]]};
            if (wrNow) begin
              nxt_hash[avs_address[3:2]] =
                merge16(hash_ff[avs_address[3:2]], avs_writedata, avs_byteenable);
            end
          end
        end
      endcase
      // read data must stand through the answer edge; writes leave it alone
      if (avs_write || ack_ff) nxt_rdata = rdata_ff;
    end
    nxt_waitReq = !nxt_ack; // registered so the pin comes straight from a flop
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlOne_ff <= RX_CTRL_ONE_RST;
      ctrlTwo_ff <= RX_CTRL_TWO_RST;
      rdata_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      waitReq_ff <= 1'b1;
      for (int i = 0; i < 3; i++) station_ff[i] <= STATION_RST;
      for (int i = 0; i < 4; i++) hash_ff[i] <= HASH_RST;
    end else begin
      ctrlOne_ff <= nxt_ctrlOne;
      ctrlTwo_ff <= nxt_ctrlTwo;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      waitReq_ff <= nxt_waitReq;
      station_ff <= nxt_station;
      hash_ff <= nxt_hash;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = waitReq_ff;
  assign qValid = qValid_ff;
  assign qData = qData_ff;
  assign qLast = qLast_ff;

  // checks: decision cycle and active scheme code
  assign scheme = {ctrlOne_ff[RXC_ALL], ctrlOne_ff[RXC_INVERSE], ctrlOne_ff[RXC_PHYS_SEL],
                   ctrlOne_ff[RXC_MULTI_SEL]};
  assign decideNow = (state_ff == ST_REPLAY) && (cnt_ff == '0);

  // an accepted frame replays all twelve header bytes back to back
  sequence accept_s;
    decideNow && accept;
  endsequence
  sequence header_out_s;
    qValid[*6] ##1 qValid[*6];
  endsequence

  promisc_pass_a: assert property (
    decideNow && scheme == 4'b1100 && !saDrop && ctrlOne_ff[RXC_ENABLE]
    && ctrlOne_ff[RXC_UNI_EN] && ctrlOne_ff[RXC_MULTI_EN] |=> qValid)
    else $error("promiscuous frame not passed");
  perfect_match_a: assert property (
    decideNow && scheme == 4'b0011 && !daExact |=> !qValid)
    else $error("perfect mode passed foreign address");
  hash_only_a: assert property (
    decideNow && scheme == 4'b0000 && !hashHit |=> !qValid)
    else $error("hash only mode passed a table miss");
  inverse_hash_a: assert property (
    decideNow && scheme == 4'b0100 && hashHit |=> !qValid)
    else $error("inverse hash mode passed a table hit");
  sa_drop_a: assert property (decideNow && saDrop |=> state_ff == ST_DROP)
    else $error("own source frame not dropped");
  drop_silent_a: assert property (state_ff == ST_DROP |=> !qValid)
    else $error("dropped frame reached queue");
  header_replay_a: assert property (accept_s |=> header_out_s)
    else $error("accepted header not replayed whole");
endmodule // rdf_filter

// [src/rdf_pkg.sv]
// Purpose: constants for the receive destination address filter
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes: hash table is 64 bits over four 16-bit registers
package rdf_pkg;
  // register byte addresses (each register one aligned word)
  localparam logic [7:0] ADDR_STATION_LOW = 8'h10;
  localparam logic [7:0] ADDR_STATION_MID = 8'h14;
  localparam logic [7:0] ADDR_STATION_HIGH = 8'h18;
  localparam logic [7:0] ADDR_RX_CTRL_ONE = 8'h74;
  localparam logic [7:0] ADDR_RX_CTRL_TWO = 8'h78;
  localparam logic [7:0] ADDR_HASH_BASE = 8'hA0;
  localparam logic [7:0] ADDR_FRAME_STAT = 8'hC0;
  localparam logic [7:0] ADDR_DROP_COUNT = 8'hC4;
  // receive_control_one field positions
  localparam int RXC_ENABLE = 0;
  localparam int RXC_INVERSE = 1;
  localparam int RXC_ALL = 4;
  localparam int RXC_UNI_EN = 5;
  localparam int RXC_MULTI_EN = 6;
  localparam int RXC_MULTI_SEL = 8;
  localparam int RXC_PHYS_SEL = 11;
  // receive_control_two field positions
  localparam int RXC2_SA_DROP = 0;
  // reset values: hash perfect scheme, receive paths enabled
  localparam logic [15:0] RX_CTRL_ONE_RST = 16'h0861;
  localparam logic [15:0] RX_CTRL_TWO_RST = 16'h0000;
  localparam logic [15:0] STATION_RST = 16'h0000;
  localparam logic [15:0] HASH_RST = 16'h0000;
  // frame layout
  localparam int ADDR_BYTES = 6;
  localparam int HEADER_BYTES = 12;
  // hash index: top six bits of the crc over the destination
  localparam int HASH_IDX_LSB = 26;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
endpackage

// [src/rdf_hash_crc.sv]
// Purpose: byte-serial crc-32 that yields the hash index
// Assumes: bytes arrive lsb first on the wire, crc reflected
// Notes: cleared at each frame start
`timescale 1ns/100ps
module rdf_hash_crc (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // byte stream
  input wire logic clear,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  // result
  output logic [5:0] hashIdx
);
  import rdf_pkg::*;
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;

  // one byte of the reflected crc per cycle
  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // next crc value
  always_comb begin
    nxt_crc = crc_ff;
    if (byteValid) begin
      // start byte seeds from init, so back-to-back frames need no idle gap
      nxt_crc = crcByte(clear ? CRC_INIT : crc_ff, byteData);
    end else if (clear) begin
      nxt_crc = CRC_INIT;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_ff <= CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  // bit selection of the finished crc
  assign hashIdx = crc_ff[HASH_IDX_LSB +: 6];
endmodule // rdf_hash_crc

// [sim/rdf_link_partner.sv]
// Purpose: far-end frame source feeding the filter byte by byte
// Assumes: frames of 14 bytes, header 12 bytes then 2 payload bytes
// Notes: idles with the inverse of the last byte so stale data never looks valid
`timescale 1ns/100ps
module rdf_link_partner (
  // clock
  input wire logic core_clk,
  // byte stream toward the filter
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxLast
);
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxLast = 1'b0;
  end

  // header back to back, then a pause so the replay is never overrun
  task automatic send(input logic [7:0] f [14]);
    for (int i = 0; i < 14; i++) begin
      if (i == 12) begin
        rxValid <= 1'b0;
        rxData <= ~f[11];
        repeat (14) @(posedge core_clk);
      end
      rxValid <= 1'b1;
      rxData <= f[i];
      rxLast <= (i == 13);
      @(posedge core_clk);
    end
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    rxData <= ~f[13];
  endtask
endmodule // rdf_link_partner

// [sim/rdf_filter_bench.sv]
// Purpose: self-checking bench for the receive address filter
// Assumes: registers over avalon-mm, frames from the link partner model
// Notes: every scheme code is swept against four destinations
`timescale 1ns/100ps
module rdf_filter_bench;
  import rdf_pkg::*;
  localparam logic [47:0] STA = 48'h001020304050;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic rxValid, rxLast, qValid, qLast;
  logic [7:0] rxData, qData;
  logic [7:0] fr [5][14];
  logic [7:0] gotQ [$];
  logic [63:0] tbl;
  logic [15:0] rd;
  logic [15:0] ctl;
  int errTotal, nCompared, lastAt, cycles, nDrop;

  rdf_filter dut_u (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast), .qValid(qValid), .qData(qData), .qLast(qLast));
  rdf_link_partner partner_u (.core_clk(core_clk), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast));

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // hang guard: whole run needs well under 20000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      finish_test();
    end
  end

  // collect what reaches the receive queue
  always @(posedge core_clk) begin
    if (qValid === 1'b1) begin
      gotQ.push_back(qData);
      if (qLast === 1'b1) lastAt = gotQ.size();
    end
  end

  task automatic finish_test();
    if (errTotal == 0 && nCompared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is seen low, then released
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  // reflected crc over the destination, top six bits index the table
  function automatic logic [5:0] hidx(input logic [7:0] f [14]);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 6; i++) begin
      c ^= {24'h000000, f[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c[31:26];
  endfunction

  // m = {all, inverse, physical select, multicast select}
  function automatic logic exp_acc(input logic [3:0] m, input logic [7:0] f [14]);
    logic uni, perf, hit, hp;
    uni = ~f[0][0];
    perf = ({f[0], f[1], f[2], f[3], f[4], f[5]} == STA);
    hit = tbl[hidx(f)];
    hp = uni ? perf : hit;
    case (m)
      4'h3: return perf;
      4'h7: return ~perf;
      4'h0: return hit;
      4'h4: return ~hit;
      4'h2: return hp;
      4'h6: return ~hp;
      4'hC: return 1'b1;
      4'h8: return uni ? hit : 1'b1;
      4'hB: return uni ? perf : 1'b1;
      4'hA: return uni ? 1'b1 : hit;
      4'h9: return uni ? 1'b1 : perf;
      default: return 1'b0;
    endcase
  endfunction

  task automatic run_frame(input logic [7:0] f [14], input logic acc);
    gotQ.delete();
    lastAt = 0;
    partner_u.send(f);
    repeat (4) @(posedge core_clk);
    check(32'(gotQ.size()), acc ? 32'h0000000E : 32'h00000000);
    if (!acc) nDrop++;
    if (acc) begin
      check(32'(lastAt), 32'h0000000E);
      for (int i = 0; i < 14; i++) check({24'h000000, gotQ[i]}, {24'h000000, f[i]});
    end
  endtask

  task automatic mk(input int k, input logic [47:0] da, input logic [47:0] sa);
    for (int i = 0; i < 6; i++) begin
      fr[k][i] = da[47 - 8 * i -: 8];
      fr[k][6 + i] = sa[47 - 8 * i -: 8];
    end
    fr[k][12] = 8'hC3;
    fr[k][13] = 8'(k);
  endtask

  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h3;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus_xfer(1'b0, ADDR_RX_CTRL_ONE, 16'h0000);
    check({16'h0000, rd}, {16'h0000, RX_CTRL_ONE_RST});
    bus_xfer(1'b0, 8'hF0, 16'h0000);
    check({16'h0000, rd}, 32'h00000000);
    mk(0, STA, 48'h00AA00BB00CC);
    mk(1, 48'h001122334455, 48'h00AA00BB00CC);
    mk(2, 48'h01005E000001, 48'h00AA00BB00CC);
    mk(3, 48'h03AABBCCDDEE, 48'h00AA00BB00CC);
    mk(4, 48'h001122334455, STA);
    // first wire byte sits in the low byte of each station word
    bus_xfer(1'b1, ADDR_STATION_LOW, {STA[39:32], STA[47:40]});
    bus_xfer(1'b1, ADDR_STATION_MID, {STA[23:16], STA[31:24]});
    bus_xfer(1'b1, ADDR_STATION_HIGH, {STA[7:0], STA[15:8]});
    bus_xfer(1'b0, ADDR_STATION_MID, 16'h0000);
    check({16'h0000, rd}, {16'h0000, STA[23:16], STA[31:24]});
    tbl = 64'h0000000000000000;
    tbl[hidx(fr[1])] = 1'b1;
    tbl[hidx(fr[2])] = 1'b1;
    for (int i = 0; i < 4; i++) bus_xfer(1'b1, ADDR_HASH_BASE + 8'(4 * i), tbl[16 * i +: 16]);
    // sweep all sixteen codes, unlisted ones reject
    for (int m = 0; m < 16; m++) begin
      ctl = 16'h0061;
      ctl[RXC_ALL] = m[3];
      ctl[RXC_INVERSE] = m[2];
      ctl[RXC_PHYS_SEL] = m[1];
      ctl[RXC_MULTI_SEL] = m[0];
      bus_xfer(1'b1, ADDR_RX_CTRL_ONE, ctl);
      for (int k = 0; k < 4; k++) run_frame(fr[k], exp_acc(m[3:0], fr[k]));
    end
    // own source address dropped only while enabled
    bus_xfer(1'b1, ADDR_RX_CTRL_TWO, 16'h0001);
    bus_xfer(1'b1, ADDR_RX_CTRL_ONE, 16'h0073);
    run_frame(fr[4], 1'b0);
    run_frame(fr[1], 1'b1);
    bus_xfer(1'b1, ADDR_RX_CTRL_TWO, 16'h0000);
    run_frame(fr[4], 1'b1);
    // status: last frame accepted, not dropping
    bus_xfer(1'b0, ADDR_FRAME_STAT, 16'h0000);
    check({16'h0000, rd}, 32'h00000002);
    // receive enables cleared: nothing passes even when promiscuous
    bus_xfer(1'b1, ADDR_RX_CTRL_ONE, 16'h0012);
    run_frame(fr[0], 1'b0);
    // every rejected frame counted once
    bus_xfer(1'b0, ADDR_DROP_COUNT, 16'h0000);
    check({16'h0000, rd}, 32'(nDrop));
    finish_test();
  end
endmodule // rdf_filter_bench
